// ==== hdl/tpc_cfg.svh ====
// Register map, field positions, limits and reset values of the terminal block
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

`define TPC_A_POL      8'h00
`define TPC_A_PRESET   8'h04
`define TPC_A_SPEC     8'h08
`define TPC_A_CTRL     8'h0c
`define TPC_A_FUNC     8'h10
`define TPC_A_HOST     8'h14
`define TPC_A_X8FN     8'h18
`define TPC_A_PMAX     8'h1c
`define TPC_A_PREQ     8'h20
`define TPC_A_GAIN_A   8'h24
`define TPC_A_GAIN_B   8'h28
`define TPC_A_RANGE    8'h2c
`define TPC_A_SRC_A    8'h30
`define TPC_A_SRC_B    8'h34
`define TPC_A_STATUS   8'h38
`define TPC_A_IRQ_ST   8'h3c
`define TPC_A_IRQ_MSK  8'h40

`define TPC_POL_RST    12'h000
`define TPC_POL_OC_A   10
`define TPC_POL_OC_B   11
`define TPC_COUNT_MAX  14'd9999
`define TPC_GAIN_MAX   11'd2000
`define TPC_GAIN_RST   11'd1000
`define TPC_GAIN_UNIT  27'd1000
`define TPC_PMAX_MAX   9'd500
`define TPC_PMAX_RST   9'd100
`define TPC_FN_PRESET  5'd12
`define TPC_FN_SPEC    5'd13
`define TPC_FN_HOST    5'd17
`define TPC_X8_DIS_LO  6'd44
`define TPC_X8_DIS_HI  6'd46
`define TPC_FULL_SCALE 16'hffff
`define TPC_LIVE_ZERO  16'd13107
`define TPC_SPAN_NUM   18'd4
`define TPC_SPAN_DEN   18'd5
`define TPC_CLK_HZ     64'd100000000
`define TPC_PULSE_UNIT_HZ 64'd100
`define TPC_CTRL_CLR   3
`define TPC_FN_B_LSB   8
`define TPC_FN_R_LSB   16
`define TPC_RNG_B_LSB  4
`define TPC_ST_ACT_LSB 16

`endif

// ==== hdl/tpc_pkg.sv ====
// Types shared by the terminal polarity and pulse counter block
package tpc_pkg;

    // Bit order matches the polarity mask layout
    typedef struct packed {
        logic       reverse_run_input;
        logic       forward_run_input;
        logic [7:0] x;
    } term_in_t;

    typedef struct packed {
        logic relay;
        logic oc_b;
        logic oc_a;
    } term_out_t;

    typedef struct packed {
        logic spec_hold;
        logic preset_hit;
    } count_ind_t;

    typedef enum logic [1:0] {
        RANGE_V0_10,
        RANGE_MA4_20,
        RANGE_MA0_20,
        RANGE_SPARE
    } range_t;

endpackage

// ==== hdl/count_unit.sv ====
// Synchronised edge counter with preset and specified count indications
`timescale 1ns/10ps
`include "tpc_cfg.svh"
module count_unit import tpc_pkg::*; (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Counting level, already polarity corrected
    input  wire logic       level_in,
    input  wire logic       clear,
    // Thresholds
    input  wire logic [13:0] preset,
    input  wire logic [13:0] specified,
    // Results
    output logic [13:0]     count,
    output count_ind_t      ind
);
    logic        sync_a;
    logic        sync_b;
    logic        last;
    logic [13:0] next_count;

    wire rise     = sync_b & ~last;
    wire at_pre   = (preset != 14'd0) && (count == preset);
    wire spec_ok  = (specified != 14'd0) && (specified <= preset);
    wire spec_win = spec_ok && (count >= specified) && (count < preset);

    // Wraps to one after the preset so the next cycle of counting starts cleanly
    always_comb begin
        next_count = count;
        if (clear)
            next_count = 14'd0;
        else if (rise && at_pre)
            next_count = 14'd1;
        else if (rise && count != `TPC_COUNT_MAX)
            next_count = count + 14'd1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last   <= 1'b0;
            count  <= 14'd0;
            ind    <= '0;
        end else begin
            sync_a <= level_in;
            sync_b <= sync_a;
            last   <= sync_b;
            count  <= next_count;
            ind    <= '{spec_hold: spec_win, preset_hit: at_pre};
        end
    end

    property p_preset_hit;
        @(posedge pclk) disable iff (!presetn)
        (preset != 14'd0 && count == preset) |=> ind.preset_hit;
    endproperty
    a_preset_hit: assert property (p_preset_hit) else $error("preset indication missing");

    property p_spec_invalid;
        @(posedge pclk) disable iff (!presetn)
        ind.spec_hold |-> ($past(specified) <= $past(preset)) && ($past(count) < $past(preset));
    endproperty
    a_spec_invalid: assert property (p_spec_invalid) else $error("specified indication out of window");

    property p_count_step;
        @(posedge pclk) disable iff (!presetn)
        (rise && !clear && count < preset) |=> count == $past(count) + 14'd1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not advance by one");

    property p_one_count_per_edge;
        @(posedge pclk) disable iff (!presetn)
        (sync_b && last && !clear) |=> count == $past(count);
    endproperty
    a_one_count_per_edge: assert property (p_one_count_per_edge) else $error("count moved on a steady level");
endmodule

// ==== hdl/pulse_out_gen.sv ====
// Phase-accumulator pulse output with frequency ceiling
`timescale 1ns/10ps
`include "tpc_cfg.svh"
module pulse_out_gen (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control, frequencies in 0.1 kHz units
    input  wire logic       enable,
    input  wire logic [8:0] req_freq,
    input  wire logic [8:0] max_freq,
    // Pin
    output logic            pulse_out
);
    // Accumulator step per 0.1 kHz; truncation keeps the output at or below the setting
    localparam logic [31:0] STEP = 32'(((64'd1 << 32) * `TPC_PULSE_UNIT_HZ) / `TPC_CLK_HZ);

    logic [31:0] acc;
    wire  [8:0]  eff  = (req_freq > max_freq) ? max_freq : req_freq;
    wire  [31:0] incr = 32'(eff) * STEP;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc       <= 32'h0000_0000;
            pulse_out <= 1'b0;
        end else begin
            acc       <= enable ? acc + incr : 32'h0000_0000;
            pulse_out <= enable & acc[31];
        end
    end

    property p_freq_cap;
        @(posedge pclk) disable iff (!presetn)
        enable && $past(enable) |-> (acc - $past(acc)) <= 32'(max_freq) * STEP || $changed(max_freq);
    endproperty
    a_freq_cap: assert property (p_freq_cap) else $error("pulse rate above ceiling");
endmodule

// ==== hdl/terminal_polarity_pulse_counter.sv ====
// Terminal polarity, count indications, output routing, analog and pulse outputs, APB registers
`timescale 1ns/10ps
`include "tpc_cfg.svh"
module terminal_polarity_pulse_counter import tpc_pkg::*; (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Terminals, high while connected to common
    input  wire term_in_t    term_raw,
    output term_in_t         term_active,
    output term_out_t        term_out,
    // Pulse and analog outputs
    output logic             pulse_out,
    output logic [15:0]      analog_out_a,
    output logic [15:0]      analog_out_b,
    output range_t           analog_range_a,
    output range_t           analog_range_b,
    // Interrupt
    output logic             irq
);
    logic [11:0] terminal_polarity_mask;
    logic [13:0] preset_count_value;
    logic [13:0] specified_count_value;
    logic [2:0]  count_select;
    logic [4:0]  func_oc_a;
    logic [4:0]  func_oc_b;
    logic [4:0]  func_relay;
    logic [2:0]  host_out;
    logic [5:0]  eighth_input_func;
    logic [8:0]  pulse_out_max_freq;
    logic [8:0]  pulse_req_freq;
    logic [10:0] analog_gain_a;
    logic [10:0] analog_gain_b;
    logic [15:0] host_value_a;
    logic [15:0] host_value_b;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic        clear_pulse;
    count_ind_t  ind;
    count_ind_t  ind_last;
    logic [13:0] count;

    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction

    // Gain in 0.1 percent steps; live-zero range squeezes the span above 20 percent
    function automatic logic [15:0] ao_scale(input logic [15:0] src,
                                             input logic [10:0] gain,
                                             input range_t      rng);
        logic [26:0] prod;
        logic [26:0] lin;
        logic [17:0] span;
        prod = 27'(src) * 27'(gain);
        lin  = prod / `TPC_GAIN_UNIT;
        if (lin > 27'(`TPC_FULL_SCALE))
            lin = 27'(`TPC_FULL_SCALE);
        span = (18'(lin[15:0]) * `TPC_SPAN_NUM) / `TPC_SPAN_DEN;
        if (rng == RANGE_MA4_20)
            ao_scale = `TPC_LIVE_ZERO + span[15:0];
        else
            ao_scale = lin[15:0];
    endfunction

    function automatic logic route(input logic [4:0] fn,
                                   input count_ind_t ci,
                                   input logic       host);
        unique case (fn)
            `TPC_FN_PRESET: route = ci.preset_hit;
            `TPC_FN_SPEC:   route = ci.spec_hold;
            `TPC_FN_HOST:   route = host;
            default:        route = 1'b0;
        endcase
    endfunction

    // Address decode
    wire sel_pol    = paddr == `TPC_A_POL;
    wire sel_preset = paddr == `TPC_A_PRESET;
    wire sel_spec   = paddr == `TPC_A_SPEC;
    wire sel_ctrl   = paddr == `TPC_A_CTRL;
    wire sel_func   = paddr == `TPC_A_FUNC;
    wire sel_host   = paddr == `TPC_A_HOST;
    wire sel_x8fn   = paddr == `TPC_A_X8FN;
    wire sel_pmax   = paddr == `TPC_A_PMAX;
    wire sel_preq   = paddr == `TPC_A_PREQ;
    wire sel_gain_a = paddr == `TPC_A_GAIN_A;
    wire sel_gain_b = paddr == `TPC_A_GAIN_B;
    wire sel_range  = paddr == `TPC_A_RANGE;
    wire sel_src_a  = paddr == `TPC_A_SRC_A;
    wire sel_src_b  = paddr == `TPC_A_SRC_B;
    wire sel_status = paddr == `TPC_A_STATUS;
    wire sel_irq_st = paddr == `TPC_A_IRQ_ST;
    wire sel_irq_mk = paddr == `TPC_A_IRQ_MSK;

    wire hit = sel_pol | sel_preset | sel_spec | sel_ctrl | sel_func | sel_host
             | sel_x8fn | sel_pmax | sel_preq | sel_gain_a | sel_gain_b | sel_range
             | sel_src_a | sel_src_b | sel_status | sel_irq_st | sel_irq_mk;

    wire setup  = psel & ~penable;
    wire access = psel & penable;
    wire wr     = access & pwrite & hit;

    assign pready  = 1'b1;
    assign pslverr = access & ~hit;

    wire [31:0] rd_mux =
          sel_pol    ? 32'(terminal_polarity_mask)
        : sel_preset ? 32'(preset_count_value)
        : sel_spec   ? 32'(specified_count_value)
        : sel_ctrl   ? 32'(count_select)
        : sel_func   ? {11'h000, func_relay, 3'h0, func_oc_b, 3'h0, func_oc_a}
        : sel_host   ? 32'(host_out)
        : sel_x8fn   ? 32'(eighth_input_func)
        : sel_pmax   ? 32'(pulse_out_max_freq)
        : sel_preq   ? 32'(pulse_req_freq)
        : sel_gain_a ? 32'(analog_gain_a)
        : sel_gain_b ? 32'(analog_gain_b)
        : sel_range  ? {26'h0, analog_range_b, 2'h0, analog_range_a}
        : sel_src_a  ? 32'(host_value_a)
        : sel_src_b  ? 32'(host_value_b)
        : sel_status ? {6'h00, term_active, 2'h0, count}
        : sel_irq_st ? 32'(irq_status)
        : sel_irq_mk ? 32'(irq_mask)
        : 32'h0000_0000;

    // Polarity: the raw connected level flipped by its mask bit
    wire term_in_t next_active = term_raw ^ terminal_polarity_mask[9:0];

    wire pulse_disable = (eighth_input_func >= `TPC_X8_DIS_LO)
                      && (eighth_input_func <= `TPC_X8_DIS_HI);

    // Events: rising edges of the two indications
    wire [1:0] events    = {ind.spec_hold & ~ind_last.spec_hold, ind.preset_hit & ~ind_last.preset_hit};
    wire [1:0] irq_clear = (wr & sel_irq_st) ? pwdata[1:0] : 2'b00;
    // Set beats clear so an event in the clearing cycle is kept
    wire [1:0] next_irq_status = (irq_status & ~irq_clear) | events;

    wire oc_a_fn = route(func_oc_a, ind, host_out[0]);
    wire oc_b_fn = route(func_oc_b, ind, host_out[1]);
    wire rl_fn   = route(func_relay, ind, host_out[2]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            terminal_polarity_mask <= `TPC_POL_RST;
            preset_count_value     <= 14'd0;
            specified_count_value  <= 14'd0;
            count_select           <= 3'd0;
            func_oc_a              <= 5'd0;
            func_oc_b              <= 5'd0;
            func_relay             <= 5'd0;
            host_out               <= 3'h0;
            eighth_input_func      <= 6'd0;
            pulse_out_max_freq     <= `TPC_PMAX_RST;
            pulse_req_freq         <= 9'd0;
            analog_gain_a          <= `TPC_GAIN_RST;
            analog_gain_b          <= `TPC_GAIN_RST;
            analog_range_a         <= RANGE_V0_10;
            analog_range_b         <= RANGE_V0_10;
            host_value_a           <= 16'h0000;
            host_value_b           <= 16'h0000;
            irq_mask               <= 2'b00;
            clear_pulse            <= 1'b0;
        end else begin
            clear_pulse <= wr & sel_ctrl & pwdata[`TPC_CTRL_CLR];
            if (wr & sel_pol)
                terminal_polarity_mask <= pwdata[11:0];
            if (wr & sel_preset)
                preset_count_value <= 14'(clamp(pwdata, 32'(`TPC_COUNT_MAX)));
            if (wr & sel_spec)
                specified_count_value <= 14'(clamp(pwdata, 32'(`TPC_COUNT_MAX)));
            if (wr & sel_ctrl)
                count_select <= pwdata[2:0];
            if (wr & sel_func) begin
                func_oc_a  <= pwdata[4:0];
                func_oc_b  <= pwdata[`TPC_FN_B_LSB +: 5];
                func_relay <= pwdata[`TPC_FN_R_LSB +: 5];
            end
            if (wr & sel_host)
                host_out <= pwdata[2:0];
            if (wr & sel_x8fn)
                eighth_input_func <= pwdata[5:0];
            if (wr & sel_pmax)
                pulse_out_max_freq <= 9'(clamp(pwdata, 32'(`TPC_PMAX_MAX)));
            if (wr & sel_preq)
                pulse_req_freq <= 9'(clamp(pwdata, 32'(`TPC_PMAX_MAX)));
            if (wr & sel_gain_a)
                analog_gain_a <= 11'(clamp(pwdata, 32'(`TPC_GAIN_MAX)));
            if (wr & sel_gain_b)
                analog_gain_b <= 11'(clamp(pwdata, 32'(`TPC_GAIN_MAX)));
            if (wr & sel_range) begin
                analog_range_a <= range_t'(pwdata[1:0]);
                analog_range_b <= range_t'(pwdata[`TPC_RNG_B_LSB +: 2]);
            end
            if (wr & sel_src_a)
                host_value_a <= pwdata[15:0];
            if (wr & sel_src_b)
                host_value_b <= pwdata[15:0];
            if (wr & sel_irq_mk)
                irq_mask <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata       <= 32'h0000_0000;
            term_active  <= '0;
            term_out     <= '0;
            ind_last     <= '0;
            irq_status   <= 2'b00;
            irq          <= 1'b0;
            analog_out_a <= 16'h0000;
            analog_out_b <= 16'h0000;
        end else begin
            if (setup)
                prdata <= rd_mux;
            term_active   <= next_active;
            term_out.oc_a <= oc_a_fn ^ terminal_polarity_mask[`TPC_POL_OC_A];
            term_out.oc_b <= oc_b_fn ^ terminal_polarity_mask[`TPC_POL_OC_B];
            term_out.relay <= rl_fn;
            ind_last      <= ind;
            irq_status    <= next_irq_status;
            irq           <= |(next_irq_status & irq_mask);
            analog_out_a  <= ao_scale(host_value_a, analog_gain_a, analog_range_a);
            analog_out_b  <= ao_scale(host_value_b, analog_gain_b, analog_range_b);
        end
    end

    count_unit u_count (
        .pclk      (pclk),
        .presetn   (presetn),
        .level_in  (term_active.x[count_select]),
        .clear     (clear_pulse),
        .preset    (preset_count_value),
        .specified (specified_count_value),
        .count     (count),
        .ind       (ind)
    );

    pulse_out_gen u_pulse (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (~pulse_disable),
        .req_freq  (pulse_req_freq),
        .max_freq  (pulse_out_max_freq),
        .pulse_out (pulse_out)
    );

    property p_pulse_off;
        @(posedge pclk) disable iff (!presetn)
        pulse_disable [*2] |-> !pulse_out;
    endproperty
    a_pulse_off: assert property (p_pulse_off) else $error("pulse output active while disabled");

    property p_polarity;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> term_active == ($past(term_raw) ^ $past(terminal_polarity_mask[9:0]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("terminal polarity wrong");

    property p_route_preset;
        @(posedge pclk) disable iff (!presetn)
        (func_oc_a == `TPC_FN_PRESET && !terminal_polarity_mask[`TPC_POL_OC_A]) |=>
            term_out.oc_a == $past(ind.preset_hit);
    endproperty
    a_route_preset: assert property (p_route_preset) else $error("preset indication not routed");

    property p_host_out;
        @(posedge pclk) disable iff (!presetn)
        func_relay == `TPC_FN_HOST |=> term_out.relay == $past(host_out[2]);
    endproperty
    a_host_out: assert property (p_host_out) else $error("host control of relay lost");

    property p_full_scale;
        @(posedge pclk) disable iff (!presetn)
        (host_value_a == `TPC_FULL_SCALE && analog_gain_a == `TPC_GAIN_RST) |=>
            analog_out_a == `TPC_FULL_SCALE;
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("host full scale not reached");

    property p_live_zero;
        @(posedge pclk) disable iff (!presetn)
        (host_value_b == 16'h0000 && analog_range_b == RANGE_MA4_20) |=> analog_out_b == `TPC_LIVE_ZERO;
    endproperty
    a_live_zero: assert property (p_live_zero) else $error("4-20 mA range lacks live zero");

    property p_mask_reset;
        @(posedge pclk) $rose(presetn) |-> terminal_polarity_mask == `TPC_POL_RST;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("polarity mask not cleared by reset");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> irq == |($past(next_irq_status) & $past(irq_mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule

// ==== tb/pulse_source.sv ====
// Switch bank and pulse source wired to the digital input terminals
`timescale 1ns/10ps
module pulse_source import tpc_pkg::*; (
    // Clock
    input  wire logic       pclk,
    // Burst request
    input  wire logic       start,
    input  wire logic [2:0] ch,
    input  wire logic [7:0] n,
    input  wire term_in_t   base,
    // Terminals and state
    output term_in_t        raw,
    output logic            busy
);
    logic [7:0] left = 8'h00;
    logic [2:0] ph   = 3'h0;
    // Three cycles closed, three open: slow enough for the input filter
    always_comb begin
        raw = base;
        raw.x[ch] = base.x[ch] ^ (busy && ph < 3'h3);
    end
    assign busy = (left != 8'h00);
    always @(posedge pclk) begin
        if (start) begin
            left <= n;
            ph <= 3'h0;
        end else if (busy) begin
            ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
            if (ph == 3'h5)
                left <= left - 8'h01;
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the terminal polarity and pulse counter block
`timescale 1ns/10ps
`include "tpc_cfg.svh"
module tb_top import tpc_pkg::*; ;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, n = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, pulse_out, irq, busy, start = 1'b0;
    logic [15:0] ao_a, ao_b;
    range_t      rg_a, rg_b;
    term_in_t    raw, act, base = '0;
    term_out_t   tout;
    int          fails = 0, checks = 0, cyc = 0, rises;
    logic [11:0] t_m [4] = '{12'h000, 12'h0ff, 12'h300, 12'hb00};
    logic [9:0]  t_r [4] = '{10'h001, 10'h0f0, 10'h000, 10'h3ff};
    logic [9:0]  t_a [4] = '{10'h001, 10'h00f, 10'h300, 10'h0ff};
    logic [2:0]  t_o [4] = '{3'h0, 3'h0, 3'h0, 3'h2};
    logic [5:0]  t_f [5] = '{6'h00, 6'h2c, 6'h2d, 6'h2e, 6'h2f};

    terminal_polarity_pulse_counter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .term_raw(raw), .term_active(act), .term_out(tout), .pulse_out(pulse_out), .analog_out_a(ao_a),
        .analog_out_b(ao_b), .analog_range_a(rg_a), .analog_range_b(rg_b), .irq(irq));
    pulse_source src (.pclk(pclk), .start(start), .ch(3'h0), .n(n), .base(base), .raw(raw), .busy(busy));

    initial forever #5 pclk = ~pclk;

    task automatic close_out;
        if (fails == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Whole run is about 40250 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            close_out();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel in the same step
        @(posedge pclk);
    endtask

    task automatic pulses(input logic [7:0] c);
        n <= c;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        @(posedge pclk);
        while (busy) @(posedge pclk);
        repeat (8) @(posedge pclk);
    endtask

    task automatic measure(input int len);
        logic p;
        rises = 0;
        p = pulse_out;
        repeat (len) begin
            @(posedge pclk);
            if (pulse_out === 1'b1 && p !== 1'b1)
                rises++;
            p = pulse_out;
        end
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `TPC_A_POL, 0);
        check("pol_rst", rd, 32'h0);
        apb(0, `TPC_A_PMAX, 0);
        check("pmax_rst", rd, 32'd100);
        for (int i = 0; i < 4; i++) begin
            apb(1, `TPC_A_POL, {20'h0, t_m[i]});
            base <= t_r[i];
            repeat (4) @(posedge pclk);
            check("term_active", {22'h0, act}, {22'h0, t_a[i]});
            check("term_out", {29'h0, tout}, {29'h0, t_o[i]});
        end
        apb(1, `TPC_A_POL, 0);
        base <= '0;
        apb(0, 8'h80, 0);
        check("unmapped", {er, rd[30:0]}, 32'h80000000);
        check("pready", {31'h0, pready}, 32'h1);
        // Preset 8, specified 5, oc_a shows preset and oc_b specified
        apb(1, `TPC_A_PRESET, 8);
        apb(1, `TPC_A_SPEC, 5);
        apb(1, `TPC_A_FUNC, 32'h0d0c);
        apb(1, `TPC_A_CTRL, 32'h8);
        pulses(5);
        check("spec_on", {29'h0, tout}, 32'h2);
        pulses(3);
        check("preset_on", {29'h0, tout}, 32'h1);
        apb(0, `TPC_A_STATUS, 0);
        check("count", rd, 32'd8);
        apb(0, `TPC_A_IRQ_ST, 0);
        check("irq_st", rd, 32'h3);
        check("irq_masked", {31'h0, irq}, 32'h0);
        apb(1, `TPC_A_IRQ_MSK, 1);
        repeat (3) @(posedge pclk);
        check("irq_on", {31'h0, irq}, 32'h1);
        apb(1, `TPC_A_IRQ_ST, 1);
        repeat (3) @(posedge pclk);
        check("irq_clr", {31'h0, irq}, 32'h0);
        apb(1, `TPC_A_SPEC, 9);
        apb(1, `TPC_A_CTRL, 32'h8);
        pulses(6);
        check("spec_bad", {29'h0, tout}, 32'h0);
        // Host control of oc_a and relay outputs and analog path
        apb(1, `TPC_A_FUNC, 32'h110011);
        apb(1, `TPC_A_HOST, 5);
        apb(1, `TPC_A_SRC_A, 32'hffff);
        repeat (3) @(posedge pclk);
        check("host_oc", {29'h0, tout}, 32'h5);
        check("full_scale", {16'h0, ao_a}, 32'hffff);
        apb(0, `TPC_A_GAIN_A, 0);
        check("gain_rst", rd, 32'd1000);
        apb(1, `TPC_A_GAIN_A, 3000);
        apb(0, `TPC_A_GAIN_A, 0);
        check("gain_clamp", rd, 32'd2000);
        apb(1, `TPC_A_GAIN_A, 500);
        apb(1, `TPC_A_RANGE, 32'h11);
        repeat (3) @(posedge pclk);
        check("range_a", {30'h0, rg_a}, {30'h0, RANGE_MA4_20});
        check("ao_4_20", {16'h0, ao_a}, 32'h9998);
        check("range_b", {30'h0, rg_b}, {30'h0, RANGE_MA4_20});
        check("ao_b_zero", {16'h0, ao_b}, 32'h3333);
        // 20 kHz requested against a 10 kHz ceiling
        apb(1, `TPC_A_PREQ, 200);
        measure(20000);
        check("pulse_clamp", {31'h0, rises >= 1 && rises <= 2}, 32'h1);
        apb(1, `TPC_A_PMAX, 600);
        apb(0, `TPC_A_PMAX, 0);
        check("pmax_clamp", rd, 32'd500);
        apb(1, `TPC_A_PREQ, 500);
        for (int i = 0; i < 5; i++) begin
            apb(1, `TPC_A_X8FN, {26'h0, t_f[i]});
            measure(4000);
            check("pulse_x8", {31'h0, rises > 0}, {31'h0, t_f[i] < 6'd44 || t_f[i] > 6'd46});
        end
        close_out();
    end
endmodule
